/* src/dsm_consts.svh */
// Timing counts and reset values for the dual-slope meter sequencer
`ifndef DSM_CONSTS_SVH
`define DSM_CONSTS_SVH
`define DSM_CLK_PERIOD_NS   8
`define DSM_T_INT_NS        10000000
`define DSM_T_INT_CYC       (`DSM_T_INT_NS / `DSM_CLK_PERIOD_NS)
`define DSM_DISCHARGE_CYC   16
`define DSM_CNT_W           20
`define DSM_CODE_W          6
`define DSM_CNT_RST         20'h0_0000
`endif

/* src/dsm_pkg.sv */
// Types for the dual-slope meter sequencer
package dsm_pkg;
  typedef enum logic [3:0] {
    DSM_DISCHARGE = 4'b0001,
    DSM_INTEGRATE = 4'b0010,
    DSM_DEINT     = 4'b0100,
    DSM_DONE      = 4'b1000
  } dsm_state_t;
endpackage

/* src/dsm_code_if.sv */
// Gray switch code and its binary decode between sequencer and decoder
`timescale 1ns/1ns
interface dsm_code_if #(parameter int W = 6);
  logic [W-1:0] gray;
  logic [W-1:0] bin;
  modport src (output gray, input bin);
  modport dec (input gray, output bin);
endinterface

/* src/dsm_gray_dec.sv */
// Reflected Gray to natural binary decoder
`timescale 1ns/1ns
module dsm_gray_dec #(
  parameter int W = 6
) (
  dsm_code_if.dec c
);
  // Each binary bit is the XOR of all Gray bits at and above it
  always_comb begin
    c.bin[W-1] = c.gray[W-1];
    for (int i = W - 2; i >= 0; i--) begin
      c.bin[i] = c.bin[i+1] ^ c.gray[i];
    end
  end
endmodule

/* src/dsm_seq.sv */
// Dual-slope converter sequencer with Gray-coded setting inputs
//
// Function
// - Start: open reset switch, select sensor voltage, integrate for 10 ms.
// - After the fixed period, switch the selector to the reference.
// - End de-integration when the comparator reports zero output.
// - Count clocks during de-integration; final count is the brightness result.
// - Then reselect sensor, close reset switches, discharge, start next cycle.
// - Each setting arrives as a parallel switch code of four to six bits.
// - Convert every Gray-coded setting to natural binary before passing it on.
`timescale 1ns/1ns
`include "dsm_consts.svh"
module dsm_seq #(
  parameter int T_INT_CYC = `DSM_T_INT_CYC,
  parameter int DIS_CYC   = `DSM_DISCHARGE_CYC,
  parameter int CNT_W     = `DSM_CNT_W,
  parameter int CODE_W    = `DSM_CODE_W
) (
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              zero_cross_i,
  input  wire logic [CODE_W-1:0] shutter_gray_i,
  input  wire logic [CODE_W-1:0] aperture_gray_i,
  input  wire logic [CODE_W-1:0] film_gray_i,
  output logic                   input_selector_switch_o,
  output logic                   integrator_reset_switch_o,
  output logic [CNT_W-1:0]       result_o,
  output logic                   result_valid_o,
  output logic                   overrange_o,
  output logic [CODE_W-1:0]      shutter_bin_o,
  output logic [CODE_W-1:0]      aperture_bin_o,
  output logic [CODE_W-1:0]      film_bin_o
);
  // ------------------------------------------------------------
  // Local constants
  // ------------------------------------------------------------
  // Shutter, aperture and film speed, packed in that order
  localparam int N_SET = 3;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  // Timer paces discharge and integration, cnt is the ramp-down count
  // Two flops per pin before decode: contacts move at any time
  typedef struct packed {
    dsm_pkg::dsm_state_t        st;
    logic [31:0]                tmr;
    logic [CNT_W-1:0]           cnt;
    logic [CNT_W-1:0]           res;
    logic                       vld;
    logic                       ovr;
    logic [1:0]                 zc_sync;
    logic [N_SET*CODE_W-1:0]    g_s1;
    logic [N_SET*CODE_W-1:0]    g_s2;
    logic [N_SET*CODE_W-1:0]    bin;
  } dsm_regs_t;

  dsm_regs_t         q, d;
  logic [CODE_W-1:0] dec_bin [N_SET];
  logic [CODE_W-1:0] bin_out [N_SET];

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // Phase timer has run its full length
  function automatic logic tmr_expired(
    input logic [31:0] tmr,
    input int          len
  );
    tmr_expired = (tmr >= 32'(len - 1));
  endfunction

  // Selector sits on the reference only while ramping down
  function automatic logic sel_ref(
    input dsm_pkg::dsm_state_t st
  );
    sel_ref = (st == dsm_pkg::DSM_DEINT);
  endfunction

  // Reset switch closed only while the capacitor discharges
  function automatic logic rst_closed(
    input dsm_pkg::dsm_state_t st
  );
    rst_closed = (st == dsm_pkg::DSM_DISCHARGE);
  endfunction

  // One setting code out of the packed triple
  function automatic logic [CODE_W-1:0] slice_code(
    input logic [N_SET*CODE_W-1:0] v,
    input int                      idx
  );
    slice_code = v[idx*CODE_W +: CODE_W];
  endfunction

  // Count has saturated at all ones
  function automatic logic cnt_full(
    input logic [CNT_W-1:0] cnt
  );
    cnt_full = &cnt;
  endfunction

  // ------------------------------------------------------------
  // Setting decoders
  // ------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < N_SET; k++) begin : g_dec
      dsm_code_if #(.W(CODE_W)) cif ();
      assign cif.gray   = slice_code(q.g_s2, k);
      assign dec_bin[k] = cif.bin;
      dsm_gray_dec #(.W(CODE_W)) u_dec (.c(cif));
    end
  endgenerate

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // Phases repeat: discharge, integrate, de-integrate, done
  // Count carries the fixed two-cycle comparator sync lag;
  // a constant offset traded for a metastability-safe edge
  always_comb begin
    d         = q;
    d.vld     = 1'b0;
    d.zc_sync = {q.zc_sync[0], zero_cross_i};
    // Switch codes are pins: two flops before decoding
    d.g_s1    = {film_gray_i, aperture_gray_i, shutter_gray_i};
    d.g_s2    = q.g_s1;
    d.bin     = {dec_bin[2], dec_bin[1], dec_bin[0]};
    case (q.st)
      dsm_pkg::DSM_DISCHARGE: begin
        if (tmr_expired(q.tmr, DIS_CYC)) begin
          d.st  = dsm_pkg::DSM_INTEGRATE;
          d.tmr = 32'h0000_0000;
        end else begin
          d.tmr = q.tmr + 32'h0000_0001;
        end
      end
      dsm_pkg::DSM_INTEGRATE: begin
        if (tmr_expired(q.tmr, T_INT_CYC)) begin
          d.st  = dsm_pkg::DSM_DEINT;
          d.tmr = 32'h0000_0000;
          d.cnt = CNT_W'(`DSM_CNT_RST);
          d.ovr = 1'b0;
        end else begin
          d.tmr = q.tmr + 32'h0000_0001;
        end
      end
      dsm_pkg::DSM_DEINT: begin
        if (q.zc_sync[1]) begin
          d.st = dsm_pkg::DSM_DONE;
        end else if (cnt_full(q.cnt)) begin
          // Saturate rather than wrap so a lost comparator edge cannot alias
          d.ovr = 1'b1;
          d.st  = dsm_pkg::DSM_DONE;
        end else begin
          d.cnt = q.cnt + CNT_W'(1);
        end
      end
      dsm_pkg::DSM_DONE: begin
        d.res = q.cnt;
        d.vld = 1'b1;
        d.st  = dsm_pkg::DSM_DISCHARGE;
        d.tmr = 32'h0000_0000;
      end
      default: begin
        d.st  = dsm_pkg::DSM_DISCHARGE;
        d.tmr = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      q.st      <= dsm_pkg::DSM_DISCHARGE;
      q.tmr     <= 32'h0000_0000;
      q.cnt     <= CNT_W'(`DSM_CNT_RST);
      q.res     <= CNT_W'(`DSM_CNT_RST);
      q.vld     <= 1'b0;
      q.ovr     <= 1'b0;
      q.zc_sync <= 2'b00;
      q.g_s1    <= '0;
      q.g_s2    <= '0;
      q.bin     <= '0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Selector high = reference, low = sensor voltage
  // Decoded straight from the state flops, so no glitch between phases
  assign input_selector_switch_o   = sel_ref(q.st);
  // Reset switch closed (high) only while discharging
  assign integrator_reset_switch_o = rst_closed(q.st);
  assign result_o       = q.res;
  assign result_valid_o = q.vld;
  assign overrange_o    = q.ovr;
  generate
    for (k = 0; k < N_SET; k++) begin : g_out
      assign bin_out[k] = slice_code(q.bin, k);
    end
  endgenerate
  assign shutter_bin_o  = bin_out[0];
  assign aperture_bin_o = bin_out[1];
  assign film_bin_o     = bin_out[2];
endmodule

/* verification/dsm_seq_sva.sv */
// Port checker for the dual-slope meter sequencer
`timescale 1ns/1ns
module dsm_seq_sva #(
  parameter int T_INT_CYC = 50,
  parameter int CNT_W     = 20,
  parameter int CODE_W    = 6
) (
  input wire logic              ref_clk_i,
  input wire logic              nrst_i,
  input wire logic              zero_cross_i,
  input wire logic [CODE_W-1:0] shutter_gray_i,
  input wire logic              input_selector_switch_o,
  input wire logic              integrator_reset_switch_o,
  input wire logic [CNT_W-1:0]  result_o,
  input wire logic              result_valid_o,
  input wire logic [CODE_W-1:0] shutter_bin_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  int int_q;
  int up_q;
  // Decode pipeline is not full until a few edges after reset
  always_ff @(posedge ref_clk_i) begin
    int_q <= (input_selector_switch_o || integrator_reset_switch_o) ? 0 : int_q + 1;
    up_q  <= !nrst_i ? 0 : (up_q < 4 ? up_q + 1 : up_q);
  end
  function automatic logic [CODE_W-1:0] g2b(input logic [CODE_W-1:0] g);
    for (int i = 0; i < CODE_W; i++)
      g2b[i] = ^(g >> i);
  endfunction
  int_len_a: assert property ($rose(input_selector_switch_o) |-> int_q == T_INT_CYC)
    else $error("integration length wrong");
  sel_rst_a: assert property (!(input_selector_switch_o && integrator_reset_switch_o))
    else $error("selector and reset switch both active");
  deint_end_a: assert property ((input_selector_switch_o && zero_cross_i)[*3]
    |-> ##[0:2] !input_selector_switch_o) else $error("de-integration did not end");
  close_a: assert property ($fell(input_selector_switch_o) |=> integrator_reset_switch_o)
    else $error("reset switch not closed after conversion");
  vpulse_a: assert property (result_valid_o |=> !result_valid_o)
    else $error("valid longer than one cycle");
  vafter_a: assert property ($fell(input_selector_switch_o) |-> ##[0:2] result_valid_o)
    else $error("no result after de-integration");
  hold_a: assert property (!result_valid_o |-> $stable(result_o))
    else $error("result changed without valid");
  gray_dec_a: assert property (up_q == 4 && $stable(shutter_gray_i)[*4]
    |-> shutter_bin_o == g2b(shutter_gray_i)) else $error("bad binary decode");
  cover property (result_valid_o);
  cover property ($rose(input_selector_switch_o));
  cover property ($fell(integrator_reset_switch_o));
endmodule

/* verification/dsm_integ_model.sv */
// Behavioural integrator with reference switch and zero comparator
`timescale 1ns/1ns
module dsm_integ_model #(
  parameter int EREF = 4
) (
  input  wire logic               clk_i,
  input  wire logic               sel_i,
  input  wire logic               rst_sw_i,
  input  wire logic signed [31:0] ex_i,
  output logic                    zero_o
);
  int acc;
  always_ff @(posedge clk_i)
    acc <= rst_sw_i ? 0 : (sel_i ? acc - EREF : acc + ex_i);
  // High whenever the output sits at zero, also while discharged
  assign zero_o = (acc <= 0);
endmodule

/* verification/testbench.sv */
// Self-checking bench for the dual-slope meter sequencer
`timescale 1ns/1ns
module testbench;
  logic        ref_clk_i, nrst_i, zero_cross_i, sel, rs, valid, ovr;
  logic [5:0]  sg, ag, fg, sb, ab, fb;
  logic [19:0] res, r1, r2, r3;
  int          ex, err_total, total_checks, cyc;
  dsm_seq #(.T_INT_CYC(50), .DIS_CYC(4)) dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .zero_cross_i(zero_cross_i), .shutter_gray_i(sg), .aperture_gray_i(ag), .film_gray_i(fg),
    .input_selector_switch_o(sel), .integrator_reset_switch_o(rs), .result_o(res),
    .result_valid_o(valid), .overrange_o(ovr), .shutter_bin_o(sb), .aperture_bin_o(ab),
    .film_bin_o(fb));
  dsm_integ_model #(.EREF(4)) partner (.clk_i(ref_clk_i), .sel_i(sel), .rst_sw_i(rs),
    .ex_i(ex), .zero_o(zero_cross_i));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Adjacent codes differ in one bit
  function automatic logic [5:0] gc(input int k);
    gc = 6'(k ^ (k >> 1));
  endfunction
  task automatic convert(input int e, output logic [19:0] r);
    @(negedge ref_clk_i) ex = e;
    do @(negedge ref_clk_i); while (valid !== 1'b1);
    r = res;
    chk(20'({sel, rs}), 20'h0_0001);
    chk(20'(ovr), 20'h0_0000);
  endtask
  // Count per level is 50 * ex / 4, plus a fixed sync lag
  task automatic scen_slope;
    convert(8, r1);
    convert(16, r2);
    convert(8, r3);
    chk(20'(r1 - 20'd100 <= 20'd3), 20'h0_0001);
    chk(r2 - r1, 20'h0_0064);
    chk(r3, r1);
  endtask
  // Reset in mid de-integration, then a clean restart
  task automatic scen_reset;
    repeat (80) @(negedge ref_clk_i);
    nrst_i = 0;
    repeat (3) @(negedge ref_clk_i);
    chk(20'({sel, rs, valid, ovr}), 20'h0_0004);
    chk(res, 20'h0_0000);
    nrst_i = 1;
    convert(8, r2);
    chk(r2, r1);
  endtask
  task automatic scen_gray;
    for (int i = 0; i < 64; i++) begin
      @(negedge ref_clk_i);
      sg = gc(i);
      ag = gc(63 - i);
      fg = gc(i ^ 21);
      repeat (4) @(negedge ref_clk_i);
      chk(20'(sb), 20'(i));
      chk(20'(ab), 20'(63 - i));
      chk(20'(fb), 20'(i ^ 21));
    end
  endtask
  initial begin
    ref_clk_i = 0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {nrst_i, sg, ag, fg} = '0;
    ex = 8;
    repeat (12) @(negedge ref_clk_i);
    nrst_i = 1;
    scen_slope();
    scen_reset();
    scen_gray();
    final_report();
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
endmodule
bind dsm_seq dsm_seq_sva #(.T_INT_CYC(T_INT_CYC), .CNT_W(CNT_W), .CODE_W(CODE_W)) u_sva (
  .ref_clk_i, .nrst_i, .zero_cross_i, .shutter_gray_i, .input_selector_switch_o,
  .integrator_reset_switch_o, .result_o, .result_valid_o, .shutter_bin_o);
